// >>> bench/gpc_pads.sv
// board model of the pins: port drive, a board driver, then pulls
// assumes the pads resolve within a cycle; floating pins wander
`timescale 1ns/1ps
module gpc_pads (
  input  wire        hclk,
  input  wire [47:0] pin_out,
  input  wire [47:0] pin_oe,
  input  wire [47:0] pull_up_en,
  input  wire [47:0] pull_dn_en,
  input  wire [47:0] ext_drv,
  input  wire [47:0] ext_val,
  output wire [47:0] pin_in
);
  reg [47:0] wander = 48'h0;
  // an undriven unpulled line changes every cycle
  always @(posedge hclk) wander <= ~wander;
  // port first, then board driver, then pull-up or pull-down
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_drv & ext_val)
    | (~ext_drv & (pull_up_en | (~pull_dn_en & wander)))));
endmodule

// >>> bench/gpc_port_sva.sv
// checker for the gpio port block, bound onto gpc_port
// assumes one hclk domain and hready fed back from hreadyout
`timescale 1ns/1ps
module gpc_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [47:0] pin_in,
  input wire [47:0] pin_oe,
  input wire [47:0] pull_up_en,
  input wire [47:0] pull_dn_en,
  input wire [47:0] func_en,
  input wire [47:0] func_dir,
  input wire [47:0] pin_event
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a transfer is taken in this cycle
  wire take = hsel && htrans[1] && hready;

  chk_resp_okay: assert property (!hresp)
    else $error("error response seen");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait");
  chk_wait_single: assert property (!hreadyout |=> hreadyout)
    else $error("wait longer than one cycle");
  chk_func_dir: assert property ((pin_oe & $past(func_en)) == ($past(func_dir) & $past(func_en)))
    else $error("function direction not obeyed");
  chk_pull_excl: assert property ((pull_up_en & pull_dn_en) == 48'h0)
    else $error("both pulls on");
  chk_event_pulse: assert property (pin_event[0] |=> !pin_event[0])
    else $error("event longer than one cycle");
  chk_event_cause: assert property (pin_event[0] |-> $past(pin_in[0], 3) != $past(pin_in[0], 4))
    else $error("event without pin change");

  cover property (take && !hwrite);
  cover property (pin_event[0]);
  cover property (pull_up_en[28] && pull_dn_en[24]);
endmodule

bind gpc_port gpc_chk gpc_chk_i (.*);

// >>> bench/gpc_port_test.sv
// testbench for gpc_port: ahb-lite master tasks and scenario tasks
// assumes the gpc_pads board model and a 50 MHz clock
`timescale 1ns/1ps
module gpc_port_test;
  reg         hclk = 1'h0;
  reg         hresetn = 1'h0;
  reg         hsel = 1'h0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'h0;
  reg  [31:0] hwdata = 32'h0;
  reg  [47:0] ext_drv = 48'h0;
  reg  [47:0] ext_val = 48'h0;
  reg  [47:0] func_en = 48'h0;
  reg  [47:0] func_dir = 48'h0;
  reg  [47:0] func_out = 48'h0;
  reg  [31:0] q;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire [47:0] pin_in, pin_out, pin_oe, pull_up_en, pull_dn_en, pin_event;
  integer     fail_count = 0, n_tests = 0, cyc = 0, ev_n = 0, e0, m;

  gpc_port gpc_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
    .func_en(func_en), .func_dir(func_dir), .func_out(func_out),
    .pin_event(pin_event));
  gpc_pads gpc_pads_i (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .ext_drv(ext_drv),
    .ext_val(ext_val), .pin_in(pin_in));

  always #10 hclk = ~hclk;
  // cycle ceiling and count of pin 0 events
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (pin_event[0] === 1'h1) ev_n <= ev_n + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  // one single word transfer, holding each phase until hready
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      q = hrdata;
    end
  endtask
  // reset values, reserved bits and an unmapped offset on every port
  task t_regs;
    for (m = 0; m < 4; m = m + 1) begin
      bus(1'h0, m * 256 + 4, 32'h0);
      cmp(q, 32'h0);
      bus(1'h0, m * 256 + 8, 32'h0);
      cmp(q, 32'h00AAAAAA);
      bus(1'h1, m * 256 + 4, 32'hFFFFFFFF);
      bus(1'h1, m * 256 + 8, 32'hFFFFFFFF);
      bus(1'h0, m * 256 + 4, 32'h0);
      cmp(q, 32'h00000FFF);
      bus(1'h0, m * 256 + 8, 32'h0);
      cmp(q, 32'h00FFFFFF);
      bus(1'h0, m * 256 + 20, 32'h0);
      cmp(q, 32'h0);
      bus(1'h1, m * 256 + 4, 32'h0);
      bus(1'h1, m * 256 + 8, 32'h00AAAAAA);
    end
  endtask
  // port 1 outputs driven and read back through the pads
  task t_out;
    begin
      bus(1'h1, 32'h104, 32'hFFF);
      bus(1'h1, 32'h100, 32'hA5A);
      tick(3);
      cmp(pin_oe[23:12], 32'hFFF);
      cmp(pin_out[23:12], 32'hA5A);
      bus(1'h0, 32'h100, 32'h0);
      cmp(q, 32'hA5A);
      bus(1'h1, 32'h104, 32'h0);
    end
  endtask
  // port 2 pull codes, then repeater holding driven-then-released levels
  task t_pulls;
    begin
      for (m = 0; m < 3; m = m + 1) begin
        bus(1'h1, 32'h208, {8'h0, {12{m[1:0]}}});
        tick(3);
        cmp(pull_up_en[35:24], (m == 0) ? 32'hFFF : 32'h0);
        cmp(pull_dn_en[35:24], (m == 1) ? 32'hFFF : 32'h0);
      end
      ext_drv[35:24] <= 12'hFFF;
      ext_val[35:24] <= 12'h0F0;
      bus(1'h1, 32'h208, 32'hFFFFFF);
      tick(6);
      ext_drv[35:24] <= 12'h0;
      tick(6);
      cmp(pull_up_en[35:24], 32'h0F0);
      cmp(pull_dn_en[35:24], 32'hF0F);
      bus(1'h0, 32'h200, 32'h0);
      cmp(q, 32'h0F0);
      bus(1'h1, 32'h208, 32'hAAAAAA);
    end
  endtask
  // a peripheral function takes pin 0 of port 3
  task t_func;
    begin
      func_en[36] <= 1'h1;
      func_dir[36] <= 1'h1;
      func_out[36] <= 1'h1;
      tick(3);
      cmp(pin_oe[36], 32'h1);
      cmp(pin_out[36], 32'h1);
      func_en[36] <= 1'h0;
    end
  endtask
  // rising, falling and both edge modes on port 0 pin 0
  task t_events;
    for (m = 0; m < 3; m = m + 1) begin
      ext_drv[0] <= 1'h1;
      ext_val[0] <= 1'h0;
      bus(1'h1, 32'h0C, m == 1);
      bus(1'h1, 32'h10, m == 2);
      tick(8);
      e0 = ev_n;
      ext_val[0] <= 1'h1;
      tick(8);
      ext_val[0] <= 1'h0;
      tick(8);
      cmp(ev_n - e0, (m == 2) ? 32'h2 : 32'h1);
    end
  endtask
  initial begin
    tick(3);
    hresetn <= 1'h1;
    hsel <= 1'h1;
    t_regs;
    t_out;
    t_pulls;
    t_func;
    t_events;
    report_and_stop;
  end
endmodule

// >>> core/gpc_port.v
// four twelve-pin gpio ports with pad pull control behind an ahb-lite slave
// assumes one synchronous hclk domain; pin levels arrive asynchronously
// and are resynchronised here; pads sit outside and take the enables
//
// Summary of operation
// - four twelve-pin ports; data, direction, config registers
// - data read gives pins, write sets outputs
// - direction bit one means output; reset input
// - enabled peripheral function overrides pin direction
// - two-bit pad field per pin, upper bits reserved
// - pad codes: up, down, none, repeater
// - pad config resets to no pull anywhere
// - repeater pulls toward the last read level
// - repeater level need not survive deep power-down
// - each pin gives rising, falling or both-edge events
`timescale 1ns/1ps
`include "gpc_defs.vh"

module gpc_port (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [47:0] pin_in,
  output reg  [47:0] pin_out,
  output reg  [47:0] pin_oe,
  output reg  [47:0] pull_up_en,
  output reg  [47:0] pull_dn_en,
  input  wire [47:0] func_en,
  input  wire [47:0] func_dir,
  input  wire [47:0] func_out,
  output reg  [47:0] pin_event
);

  // bus phase states, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_READ = 2'b10;

  reg [1:0]  state;
  reg        wr_pend;
  reg [1:0]  ph_port;
  reg [7:0]  ph_ofs;

  // software state, all ports packed
  reg [47:0] out_val;
  reg [47:0] dir;
  reg [95:0] cfg;
  reg [47:0] edge_fall;
  reg [47:0] edge_both;

  // pin synchronisers and edge history
  reg [47:0] pin_meta;
  reg [47:0] pin_sync;
  reg [47:0] pin_prev;

  wire       bus_take;
  wire [1:0] a_port;
  wire [7:0] a_ofs;

  reg [47:0] next_oe;
  reg [47:0] next_out;
  reg [47:0] next_up;
  reg [47:0] next_dn;
  reg [47:0] next_event;
  integer    i;
  integer    j;
  integer    k;

  // pull-up enable for one pad field and the pin level
  function pad_up;
    input [1:0] code;
    input       level;
    begin
      case (code)
        `GPC_PAD_UP:   pad_up = 1'b1;
        `GPC_PAD_DOWN: pad_up = 1'b0;
        `GPC_PAD_NONE: pad_up = 1'b0;
        `GPC_PAD_KEEP: pad_up = level;
        default:       pad_up = 1'b0;
      endcase
    end
  endfunction

  // pull-down enable for one pad field and the pin level
  function pad_dn;
    input [1:0] code;
    input       level;
    begin
      case (code)
        `GPC_PAD_UP:   pad_dn = 1'b0;
        `GPC_PAD_DOWN: pad_dn = 1'b1;
        `GPC_PAD_NONE: pad_dn = 1'b0;
        `GPC_PAD_KEEP: pad_dn = ~level;
        default:       pad_dn = 1'b0;
      endcase
    end
  endfunction

  // true when an offset names a writable register
  function ofs_known;
    input [7:0] ofs;
    begin
      case (ofs)
        `GPC_OFS_DATA: ofs_known = 1'b1;
        `GPC_OFS_DIR:  ofs_known = 1'b1;
        `GPC_OFS_CFG:  ofs_known = 1'b1;
        `GPC_OFS_FALL: ofs_known = 1'b1;
        `GPC_OFS_BOTH: ofs_known = 1'b1;
        default:       ofs_known = 1'b0;
      endcase
    end
  endfunction

  // twelve-bit field of one port out of a packed 48-bit vector
  function [11:0] pick12;
    input [47:0] vec;
    input [1:0]  port;
    begin
      case (port)
        2'h0:    pick12 = vec[11:0];
        2'h1:    pick12 = vec[23:12];
        2'h2:    pick12 = vec[35:24];
        2'h3:    pick12 = vec[47:36];
        default: pick12 = vec[11:0];
      endcase
    end
  endfunction

  // twenty-four-bit pad field of one port out of the packed config
  function [23:0] pick24;
    input [95:0] vec;
    input [1:0]  port;
    begin
      case (port)
        2'h0:    pick24 = vec[23:0];
        2'h1:    pick24 = vec[47:24];
        2'h2:    pick24 = vec[71:48];
        2'h3:    pick24 = vec[95:72];
        default: pick24 = vec[23:0];
      endcase
    end
  endfunction

  // address phase accepted when selected and nonseq or seq
  assign bus_take = hsel & htrans[1] & hready;
  assign a_port   = haddr[`GPC_PORT_MSB:`GPC_PORT_LSB];
  assign a_ofs    = haddr[7:0];

  // bus timing as seen by a master:
  //   write: address phase taken at edge c0, data phase c1 with
  //   hreadyout high, register updated at the edge ending c1, pads
  //   follow one edge later
  //   read: address phase taken at edge c0, wait cycle c1 with
  //   hreadyout low, hrdata loaded at the edge ending c1 and taken
  //   by the master at the edge ending c2
  // hresp is never raised; unknown offsets read zero and drop writes
  // pin timing:
  //   a pin change before edge e reaches pin_sync after edge e+1
  //   and gives a one-cycle pin_event after edge e+2
  //   repeater pulls follow pin_sync one register later, so a
  //   released pin is held by the pull of its last synced level
  // hazard: edges closer than two cycles apart may merge
  //
  // bus phase tracking; reads get one wait state so a write
  // finishing in the same cycle is visible to the read, except at the data offset, which reads the synced pins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ST_IDLE;
      wr_pend   <= 1'b0;
      ph_port   <= 2'h0;
      ph_ofs    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      case (state)
        ST_IDLE: begin
          wr_pend <= bus_take & hwrite;
          if (bus_take) begin
            ph_port <= a_port;
            ph_ofs  <= a_ofs;
          end
          if (bus_take && !hwrite) begin
            state     <= ST_READ;
            hreadyout <= 1'b0;
          end
        end
        ST_READ: begin
          wr_pend   <= 1'b0;
          state     <= ST_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          wr_pend   <= 1'b0;
          state     <= ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // read data, loaded at the end of the wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (state == ST_READ) begin
      case (ph_ofs)
        `GPC_OFS_DATA:
          hrdata <= {20'h00000, pick12(pin_sync, ph_port)};
        `GPC_OFS_DIR:
          hrdata <= {20'h00000, pick12(dir, ph_port)};
        `GPC_OFS_CFG:
          hrdata <= {8'h00, pick24(cfg, ph_port)};
        `GPC_OFS_FALL:
          hrdata <= {20'h00000, pick12(edge_fall, ph_port)};
        `GPC_OFS_BOTH:
          hrdata <= {20'h00000, pick12(edge_both, ph_port)};
        default:
          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // register writes in the data phase; upper bits are dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_val   <= {`GPC_PORTS{`GPC_RST_DATA}};
      dir       <= {`GPC_PORTS{`GPC_RST_DIR}};
      cfg       <= {`GPC_PORTS{`GPC_RST_CFG}};
      edge_fall <= {`GPC_PORTS{`GPC_RST_EDGE}};
      edge_both <= {`GPC_PORTS{`GPC_RST_EDGE}};
    end else if (wr_pend && ofs_known(ph_ofs)) begin
      case (ph_ofs)
        `GPC_OFS_DATA:
          out_val[ph_port*12 +: 12] <= hwdata[11:0];
        `GPC_OFS_DIR:
          dir[ph_port*12 +: 12] <= hwdata[11:0];
        `GPC_OFS_CFG:
          cfg[ph_port*24 +: 24] <= hwdata[23:0];
        `GPC_OFS_FALL:
          edge_fall[ph_port*12 +: 12] <= hwdata[11:0];
        `GPC_OFS_BOTH:
          edge_both[ph_port*12 +: 12] <= hwdata[11:0];
        default:
          out_val <= out_val;
      endcase
    end
  end

  // two-flop synchroniser for the pin levels, then edge history
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 48'h0000_0000_0000;
      pin_sync <= 48'h0000_0000_0000;
      pin_prev <= 48'h0000_0000_0000;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // pad drive: an enabled function owns direction and value
  always @* begin
    next_oe  = 48'h0000_0000_0000;
    next_out = 48'h0000_0000_0000;
    for (i = 0; i < `GPC_ALL_PINS; i = i + 1) begin
      if (func_en[i]) begin
        next_oe[i]  = func_dir[i];
        next_out[i] = func_out[i];
      end else begin
        next_oe[i]  = dir[i];
        next_out[i] = out_val[i];
      end
    end
  end

  // pull enables from each pin's pad field and synced level
  always @* begin
    next_up = 48'h0000_0000_0000;
    next_dn = 48'h0000_0000_0000;
    for (j = 0; j < `GPC_ALL_PINS; j = j + 1) begin
      next_up[j] = pad_up(cfg[2*j +: 2], pin_sync[j]);
      next_dn[j] = pad_dn(cfg[2*j +: 2], pin_sync[j]);
    end
  end

  // edge events: both edges, falling only, or rising by default
  always @* begin
    next_event = 48'h0000_0000_0000;
    for (k = 0; k < `GPC_ALL_PINS; k = k + 1) begin
      if (edge_both[k])
        next_event[k] = pin_sync[k] ^ pin_prev[k];
      else if (edge_fall[k])
        next_event[k] = ~pin_sync[k] & pin_prev[k];
      else
        next_event[k] = pin_sync[k] & ~pin_prev[k];
    end
  end

  // pad drive outputs; reset leaves every pin an input
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_oe  <= 48'h0000_0000_0000;
      pin_out <= 48'h0000_0000_0000;
    end else begin
      pin_oe  <= next_oe;
      pin_out <= next_out;
    end
  end

  // pull outputs; repeater state lives only in the pad pulls,
  // so nothing here tries to keep it through power-down
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_up_en <= 48'h0000_0000_0000;
      pull_dn_en <= 48'h0000_0000_0000;
    end else begin
      pull_up_en <= next_up;
      pull_dn_en <= next_dn;
    end
  end

  // event pulses, one cycle each
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_event <= 48'h0000_0000_0000;
    end else begin
      pin_event <= next_event;
    end
  end

endmodule

// >>> inc/gpc_defs.vh
// register map, field layout and reset values of the gpio port block
// assumes byte addresses from a 32-bit ahb-lite bus, one word per register
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH

// port count and pins per port
`define GPC_PORTS        4
`define GPC_PINS         12
`define GPC_ALL_PINS     48

// port select field of the byte address
`define GPC_PORT_MSB     9
`define GPC_PORT_LSB     8

// register offsets inside one port window
`define GPC_OFS_DATA     8'h00
`define GPC_OFS_DIR      8'h04
`define GPC_OFS_CFG      8'h08
`define GPC_OFS_FALL     8'h0C
`define GPC_OFS_BOTH     8'h10

// reset values
`define GPC_RST_DATA     12'h000
`define GPC_RST_DIR      12'h000
`define GPC_RST_CFG      24'hAAAAAA
`define GPC_RST_EDGE     12'h000

// pad configuration encodings
`define GPC_PAD_UP       2'h0
`define GPC_PAD_DOWN     2'h1
`define GPC_PAD_NONE     2'h2
`define GPC_PAD_KEEP     2'h3

`endif
